//--- verilog/tcw_consts.vh
// Constants of the 16-bit timer compare and waveform block.
// Assumes inclusion by bare name from the design files only.
`ifndef TCW_CONSTS_VH
`define TCW_CONSTS_VH

// =====================================================================
// Waveform mode select codes
`define TCW_WGM_NORMAL    4'h0
`define TCW_WGM_CTC_A     4'h4
`define TCW_WGM_FAST8     4'h5
`define TCW_WGM_FAST9     4'h6
`define TCW_WGM_FAST10    4'h7
`define TCW_WGM_CTC_CAP   4'hc
`define TCW_WGM_FAST_CAP  4'he
`define TCW_WGM_FAST_A    4'hf

// =====================================================================
// Compare output mode codes
`define TCW_COM_OFF       2'h0
`define TCW_COM_TOGGLE    2'h1
`define TCW_COM_CLEAR     2'h2
`define TCW_COM_SET       2'h3

// =====================================================================
// Counter limits and fixed tops
`define TCW_BOTTOM        16'h0000
`define TCW_MAX           16'hffff
`define TCW_TOP8          16'h00ff
`define TCW_TOP9          16'h01ff
`define TCW_TOP10         16'h03ff

// =====================================================================
// Reset values
`define TCW_RST_COUNT     16'h0000
`define TCW_RST_COMPARE   16'h0000
`define TCW_RST_CAPTURE   16'h0000
`define TCW_RST_STATE     1'b0
`define TCW_RST_FLAG      1'b0
`define TCW_RST_OE_N      1'b1

`endif

//--- verilog/tcw_channel.v
// One compare channel: compare buffer, active compare value, output
// state and the port override that drives its pin.
// Assumes counter, tick and top detection come from the timer top.
`timescale 1ns/100ps
`default_nettype none
`include "tcw_consts.vh"

module tcw_channel (
    input  wire        clk,
    input  wire        srst,
    input  wire        tick,
    input  wire        blocked,
    input  wire        top_hit,
    input  wire        pwm_mode,
    input  wire        toggle_ok,
    input  wire [1:0]  mode,
    input  wire        force_strobe,
    input  wire        wr,
    input  wire [15:0] wdata,
    input  wire [15:0] counter,
    input  wire        port_value,
    input  wire        dir_out,
    output wire        hit,
    output reg  [15:0] cmp_q,
    output reg         state_q,
    output reg         pin_q,
    output reg         oe_n_q
);

    reg  [15:0] buf_q;
    reg         state_d;

    // =================================================================
    // Compare match
    // R20 match has no top check; a counter past top still matches
    assign hit = tick & ~blocked & (counter == cmp_q);

    // =================================================================
    // Compare value: direct in non-PWM modes, buffered in PWM modes
    always @(posedge clk)
    begin
        if (srst)
        begin
            buf_q <= `TCW_RST_COMPARE;
            cmp_q <= `TCW_RST_COMPARE;
        end
        else
        begin
            if (wr)
            begin
                buf_q <= wdata;
            end
            // R24 buffer copy at top
            if (wr && !pwm_mode)
            begin
                cmp_q <= wdata;
            end
            else if (pwm_mode && top_hit)
            begin
                cmp_q <= buf_q;
            end
        end
    end

    // =================================================================
    // Output state
    always @*
    begin
        state_d = state_q;
        if (!pwm_mode)
        begin
            // R5 force acts now
            if (hit || force_strobe)
            begin
                case (mode)
                    // R12 toggle on match
                    `TCW_COM_TOGGLE: state_d = ~state_q;
                    `TCW_COM_CLEAR:  state_d = 1'b0;
                    `TCW_COM_SET:    state_d = 1'b1;
                    // R4 zero does nothing
                    default:         state_d = state_q;
                endcase
            end
        end
        else
        begin
            // R15 match then bottom
            if (hit)
            begin
                case (mode)
                    `TCW_COM_TOGGLE: state_d = toggle_ok ? ~state_q
                                                         : state_q;
                    // R23 two non-inverted
                    `TCW_COM_CLEAR:  state_d = 1'b0;
                    // R23 three inverted
                    `TCW_COM_SET:    state_d = 1'b1;
                    default:         state_d = state_q;
                endcase
            end
            // Bottom wins so compare equal to top gives a steady level
            if (top_hit && mode == `TCW_COM_CLEAR)
            begin
                state_d = 1'b1;
            end
            else if (top_hit && mode == `TCW_COM_SET)
            begin
                state_d = 1'b0;
            end
        end
    end

    always @(posedge clk)
    begin
        // R1 reset clears state
        if (srst)
        begin
            state_q <= `TCW_RST_STATE;
            pin_q   <= `TCW_RST_STATE;
            oe_n_q  <= `TCW_RST_OE_N;
        end
        else
        begin
            state_q <= state_d;
            // R2 mode overrides port
            pin_q   <= (mode != `TCW_COM_OFF) ? state_q : port_value;
            // R3 drive only as output
            oe_n_q  <= ~dir_out;
        end
    end

endmodule // tcw_channel
`default_nettype wire

//--- verilog/tcw_timer.v
// Operation
// R1 - System reset clears every channel output state to zero.
// R2 - Nonzero output mode replaces the port value with channel state.
// R3 - Pin shows the value only while its direction bit selects output.
// R4 - Output mode zero leaves the state unchanged on a match.
// R5 - New output mode acts at next match; force acts now outside PWM.
// R6 - Output mode never touches the input capture path.
// R7 - Mode 0 counts up always and wraps from max to zero.
// R8 - Normal mode sets overflow as the counter becomes zero.
// R9 - Clear-on-match clears at compare A (mode 4) or capture (mode 12).
// R10 - Clear-on-match top is unbuffered; a missed top runs to max.
// R11 - Clear-on-match top sets compare A flag or capture flag.
// R12 - Channel A mode 1 toggles its state on each match; in PWM the code toggles only in mode 15.
// R13 - Clear-on-match sets overflow when passing max to zero.
// R14 - Modes 5, 6, 7, 14, 15 count bottom to top, restart at bottom.
// R15 - Non-inverting clears on match, sets at bottom; inverting opposite.
// R16 - Fast PWM top is fixed, capture or compare A; clear next tick.
// R17 - Register tops range from 0x0003 up to the full maximum.
// R18 - Fast PWM sets overflow and the top register flag at top.
// R19 - A channel match in fast PWM sets its match flag.
// R20 - Compare values above top never match; the code has no top check, so a counter run past top still matches them.
// R21 - Fixed top masks compare writes to the selected resolution.
// R22 - Capture top register takes writes at once.
// R23 - In PWM, output mode 2 is non-inverted, 3 inverted.
// R24 - PWM compare A writes are buffered and loaded at top.
//
// Counter, top logic and flags of a 16-bit timer with three compare
// channels. Assumes timer_tick is a one-cycle pulse from a prescaler
// and that all inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "tcw_consts.vh"

module tcw_timer (
    input  wire        clk,
    input  wire        srst,
    input  wire        timer_tick,
    input  wire [3:0]  waveform_mode_select,
    input  wire [1:0]  channel_a_output_mode,
    input  wire [1:0]  channel_b_output_mode,
    input  wire [1:0]  channel_c_output_mode,
    input  wire        force_match_strobe_a,
    input  wire        force_match_strobe_b,
    input  wire        force_match_strobe_c,
    input  wire        compare_wr_a,
    input  wire        compare_wr_b,
    input  wire        compare_wr_c,
    input  wire [15:0] compare_wdata,
    input  wire        capture_top_wr,
    input  wire [15:0] capture_top_wdata,
    input  wire        capture_event,
    input  wire        counter_wr,
    input  wire [15:0] counter_wdata,
    input  wire        overflow_flag_clr,
    input  wire        match_flag_clr_a,
    input  wire        match_flag_clr_b,
    input  wire        match_flag_clr_c,
    input  wire        capture_flag_clr,
    input  wire        port_value_a,
    input  wire        port_value_b,
    input  wire        port_value_c,
    input  wire        output_pin_direction_bit_a,
    input  wire        output_pin_direction_bit_b,
    input  wire        output_pin_direction_bit_c,
    output wire [15:0] counter_value,
    output wire [15:0] capture_top_reg,
    output wire [15:0] channel_a_compare_reg,
    output wire [15:0] channel_b_compare_reg,
    output wire [15:0] channel_c_compare_reg,
    output wire        overflow_flag,
    output wire        channel_a_match_flag,
    output wire        channel_b_match_flag,
    output wire        channel_c_match_flag,
    output wire        capture_event_flag,
    output wire        channel_a_output_state,
    output wire        channel_b_output_state,
    output wire        channel_c_output_state,
    output wire        pin_out_a,
    output wire        pin_out_b,
    output wire        pin_out_c,
    output wire        pin_oe_n_a,
    output wire        pin_oe_n_b,
    output wire        pin_oe_n_c
);

    // =================================================================
    // State
    reg  [15:0] cnt_q;
    reg  [15:0] cnt_d;
    reg  [15:0] cap_q;
    reg         block_q;
    reg         ovf_q;
    reg  [2:0]  mflag_q;
    reg         capf_q;

    reg  [15:0] top_val;
    reg  [15:0] wr_mask;
    reg         pwm_mode;
    reg         ctc_mode;
    reg         top_is_cap;

    wire        top_hit;
    wire        wrap_hit;
    wire        ovf_set;
    wire        capf_set;
    wire [15:0] wdata_m;

    wire [5:0]  mode_v;
    wire [2:0]  force_v;
    wire [2:0]  wr_v;
    wire [2:0]  port_v;
    wire [2:0]  dir_v;
    wire [2:0]  clr_v;
    wire [2:0]  hit_v;
    wire [2:0]  state_v;
    wire [2:0]  pin_v;
    wire [2:0]  oen_v;
    wire [47:0] cmp_v;

    assign mode_v  = {channel_c_output_mode, channel_b_output_mode,
                      channel_a_output_mode};
    assign force_v = {force_match_strobe_c, force_match_strobe_b,
                      force_match_strobe_a};
    assign wr_v    = {compare_wr_c, compare_wr_b, compare_wr_a};
    assign port_v  = {port_value_c, port_value_b, port_value_a};
    assign dir_v   = {output_pin_direction_bit_c,
                      output_pin_direction_bit_b,
                      output_pin_direction_bit_a};
    assign clr_v   = {match_flag_clr_c, match_flag_clr_b,
                      match_flag_clr_a};

    // =================================================================
    // Mode decode and top selection
    always @*
    begin
        pwm_mode   = 1'b0;
        ctc_mode   = 1'b0;
        top_is_cap = 1'b0;
        wr_mask    = `TCW_MAX;
        // R7 plain count to max
        top_val    = `TCW_MAX;
        case (waveform_mode_select)
            // R9 clear at compare A
            `TCW_WGM_CTC_A:
            begin
                ctc_mode = 1'b1;
                top_val  = cmp_v[15:0];
            end
            // R9 clear at capture
            `TCW_WGM_CTC_CAP:
            begin
                ctc_mode   = 1'b1;
                top_is_cap = 1'b1;
                top_val    = cap_q;
            end
            // R16 fixed tops
            `TCW_WGM_FAST8:
            begin
                pwm_mode = 1'b1;
                top_val  = `TCW_TOP8;
                wr_mask  = `TCW_TOP8;
            end
            `TCW_WGM_FAST9:
            begin
                pwm_mode = 1'b1;
                top_val  = `TCW_TOP9;
                wr_mask  = `TCW_TOP9;
            end
            `TCW_WGM_FAST10:
            begin
                pwm_mode = 1'b1;
                top_val  = `TCW_TOP10;
                wr_mask  = `TCW_TOP10;
            end
            // R16 register tops
            // R17 full range tops
            `TCW_WGM_FAST_CAP:
            begin
                pwm_mode   = 1'b1;
                top_is_cap = 1'b1;
                top_val    = cap_q;
            end
            `TCW_WGM_FAST_A:
            begin
                pwm_mode = 1'b1;
                top_val  = cmp_v[15:0];
            end
            // Dual-slope codes are not built here; they count as mode 0
            default:
            begin
                pwm_mode = 1'b0;
            end
        endcase
    end

    // R21 mask fixed resolution
    assign wdata_m = compare_wdata & wr_mask;

    // R10 live top compare
    assign top_hit  = timer_tick & ~block_q & (pwm_mode | ctc_mode) &
                      (cnt_q == top_val);
    assign wrap_hit = timer_tick & (cnt_q == `TCW_MAX);

    // =================================================================
    // Counter
    always @*
    begin
        cnt_d = cnt_q;
        if (counter_wr)
        begin
            cnt_d = counter_wdata;
        end
        // R14 restart at bottom
        else if (top_hit)
        begin
            cnt_d = `TCW_BOTTOM;
        end
        // R7 wraps past max
        else if (timer_tick)
        begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            cnt_q   <= `TCW_RST_COUNT;
            cap_q   <= `TCW_RST_CAPTURE;
            block_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            // R22 capture top unbuffered
            if (capture_top_wr)
            begin
                cap_q <= capture_top_wdata;
            end
            // A counter write hides the matches of the next tick
            if (counter_wr)
            begin
                block_q <= 1'b1;
            end
            else if (timer_tick)
            begin
                block_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // Flags: a set in the cycle of a clear wins
    // R8 overflow at wrap
    // R13 overflow max to zero
    // R18 overflow at top
    assign ovf_set  = pwm_mode ? top_hit : wrap_hit;
    // R11 capture flag at top
    // R6 capture path independent
    assign capf_set = (top_hit & top_is_cap) |
                      (capture_event & ~top_is_cap);

    always @(posedge clk)
    begin
        if (srst)
        begin
            ovf_q  <= `TCW_RST_FLAG;
            capf_q <= `TCW_RST_FLAG;
        end
        else
        begin
            ovf_q  <= ovf_set | (ovf_q & ~overflow_flag_clr);
            capf_q <= capf_set | (capf_q & ~capture_flag_clr);
        end
    end

    // =================================================================
    // Compare channels
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_ch
            tcw_channel u_ch (
                .clk          (clk),
                .srst         (srst),
                .tick         (timer_tick),
                .blocked      (block_q),
                .top_hit      (top_hit),
                .pwm_mode     (pwm_mode),
                .toggle_ok    ((gi == 0) &&
                               (waveform_mode_select == `TCW_WGM_FAST_A)),
                .mode         (mode_v[2*gi+1:2*gi]),
                .force_strobe (force_v[gi] & ~pwm_mode),
                .wr           (wr_v[gi]),
                .wdata        (wdata_m),
                .counter      (cnt_q),
                .port_value   (port_v[gi]),
                .dir_out      (dir_v[gi]),
                .hit          (hit_v[gi]),
                .cmp_q        (cmp_v[16*gi+15:16*gi]),
                .state_q      (state_v[gi]),
                .pin_q        (pin_v[gi]),
                .oe_n_q       (oen_v[gi])
            );

            // R19 match sets flag
            // R11 compare A flag at top
            always @(posedge clk)
            begin
                if (srst)
                begin
                    mflag_q[gi] <= `TCW_RST_FLAG;
                end
                else
                begin
                    mflag_q[gi] <= hit_v[gi] |
                                   (mflag_q[gi] & ~clr_v[gi]);
                end
            end
        end
    endgenerate

    // =================================================================
    // Outputs, all straight from flip-flops
    assign counter_value          = cnt_q;
    assign capture_top_reg        = cap_q;
    assign channel_a_compare_reg  = cmp_v[15:0];
    assign channel_b_compare_reg  = cmp_v[31:16];
    assign channel_c_compare_reg  = cmp_v[47:32];
    assign overflow_flag          = ovf_q;
    assign channel_a_match_flag   = mflag_q[0];
    assign channel_b_match_flag   = mflag_q[1];
    assign channel_c_match_flag   = mflag_q[2];
    assign capture_event_flag     = capf_q;
    assign channel_a_output_state = state_v[0];
    assign channel_b_output_state = state_v[1];
    assign channel_c_output_state = state_v[2];
    assign pin_out_a              = pin_v[0];
    assign pin_out_b              = pin_v[1];
    assign pin_out_c              = pin_v[2];
    assign pin_oe_n_a             = oen_v[0];
    assign pin_oe_n_b             = oen_v[1];
    assign pin_oe_n_c             = oen_v[2];

endmodule // tcw_timer
`default_nettype wire

//--- testbench/tcw_monitor.sv
// Concurrent checks on the ports of the timer compare and waveform top.
// Assumes one clk domain with synchronous active-high srst.
`timescale 1ns/100ps
`default_nettype none

module tcw_monitor (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        timer_tick,
    input wire logic [3:0]  waveform_mode_select,
    input wire logic [1:0]  channel_a_output_mode,
    input wire logic        force_match_strobe_a,
    input wire logic        counter_wr,
    input wire logic        output_pin_direction_bit_a,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] channel_a_compare_reg,
    input wire logic        overflow_flag,
    input wire logic        channel_a_match_flag,
    input wire logic        channel_a_output_state,
    input wire logic        pin_out_a,
    input wire logic        pin_oe_n_a
);
    logic blocked_q;
    wire  live_tick;

    // =================================================================
    // Match blocking: a counter write masks the next tick's matches
    always @(posedge clk)
    begin
        if (srst)
            blocked_q <= 1'b0;
        else if (counter_wr)
            blocked_q <= 1'b1;
        else if (timer_tick)
            blocked_q <= 1'b0;
    end

    assign live_tick = timer_tick && !counter_wr && !blocked_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // =================================================================
    // Port override and pin enable
    // override by state
    a_pin_shows_state: assert property (
        channel_a_output_mode != 2'h0 |=>
        pin_out_a == $past(channel_a_output_state))
        else $error("pin does not carry the channel state");
    a_oe_follows_dir: assert property (
        !srst |=> pin_oe_n_a == !$past(output_pin_direction_bit_a))
        else $error("pin enable does not follow the direction bit");
    a_off_holds_state: assert property (
        channel_a_output_mode == 2'h0 |=> $stable(channel_a_output_state))
        else $error("state changed with output mode off");
    a_force_sets_state: assert property (
        waveform_mode_select == 4'h0 && force_match_strobe_a &&
        channel_a_output_mode == 2'h3 |=> channel_a_output_state)
        else $error("forced set did not reach the state");

    // =================================================================
    // Counting and flags
    // normal increments
    a_normal_counts_up: assert property (
        waveform_mode_select == 4'h0 && timer_tick && !counter_wr |=>
        counter_value == $past(counter_value) + 16'h0001)
        else $error("normal mode did not increment");
    a_normal_sets_ovf: assert property (
        waveform_mode_select == 4'h0 && timer_tick && !counter_wr &&
        counter_value == 16'hffff |=> overflow_flag && counter_value == 0)
        else $error("wrap did not set overflow");
    a_ctc_clears_top: assert property (
        waveform_mode_select == 4'h4 && live_tick &&
        counter_value == channel_a_compare_reg |=>
        counter_value == 16'h0000 && channel_a_match_flag)
        else $error("clear-on-match top not handled");
    a_fast_top_wraps: assert property (
        waveform_mode_select == 4'h5 && live_tick &&
        counter_value == 16'h00ff |=> counter_value == 0 && overflow_flag)
        else $error("fixed top did not clear with overflow");
    a_pwm_set_bottom: assert property (
        waveform_mode_select == 4'h5 && live_tick &&
        counter_value == 16'h00ff && channel_a_output_mode == 2'h2 |=>
        channel_a_output_state)
        else $error("non-inverted output not set at bottom");
    a_pwm_clear_match: assert property (
        waveform_mode_select == 4'h5 && live_tick &&
        counter_value == channel_a_compare_reg &&
        counter_value != 16'h00ff && channel_a_output_mode == 2'h2 |=>
        !channel_a_output_state)
        else $error("non-inverted output not cleared on match");
endmodule // tcw_monitor

bind tcw_timer tcw_monitor mon_u (
    .clk(clk), .srst(srst), .timer_tick(timer_tick),
    .waveform_mode_select(waveform_mode_select),
    .channel_a_output_mode(channel_a_output_mode),
    .force_match_strobe_a(force_match_strobe_a),
    .counter_wr(counter_wr),
    .output_pin_direction_bit_a(output_pin_direction_bit_a),
    .counter_value(counter_value),
    .channel_a_compare_reg(channel_a_compare_reg),
    .overflow_flag(overflow_flag),
    .channel_a_match_flag(channel_a_match_flag),
    .channel_a_output_state(channel_a_output_state),
    .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a)
);

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the timer compare and waveform top.
// Assumes the monitor binds itself; one 125 MHz clock, strobes by index.
`timescale 1ns/100ps
`default_nettype none

module tb;
    // Mode and top per loop step: fixed, capture and compare A tops
    localparam [19:0] md_tab = 20'hfe765;
    localparam [79:0] tp_tab = 80'h0034_0003_03ff_01ff_00ff;
    localparam [7:0]  fc_tab = 8'h63;
    localparam [3:0]  fx_tab = 4'hb;
    reg         clk;
    reg         srst;
    reg         tick;
    reg  [3:0]  wgm;
    reg  [5:0]  om;
    reg  [13:0] st;
    reg  [15:0] dat;
    reg  [2:0]  pv;
    reg  [2:0]  dr;
    reg         s0;
    wire [15:0] cnt, cap, cmp_a, cmp_b, cmp_c;
    wire [5:0]  xo;
    wire        ovf, mf_a, mf_b, cap_f, s_a, s_b, po_a, oen_a;
    integer     n_mismatch;
    integer     total_checks;
    integer     i;

    tcw_timer dut_u (
        .clk(clk), .srst(srst), .timer_tick(tick),
        .waveform_mode_select(wgm), .channel_a_output_mode(om[1:0]),
        .channel_b_output_mode(om[3:2]), .channel_c_output_mode(om[5:4]),
        .force_match_strobe_a(st[0]), .force_match_strobe_b(st[1]),
        .force_match_strobe_c(st[2]), .compare_wr_a(st[3]),
        .compare_wr_b(st[4]), .compare_wr_c(st[5]), .compare_wdata(dat),
        .capture_top_wr(st[6]), .capture_top_wdata(dat),
        .capture_event(st[7]), .counter_wr(st[8]), .counter_wdata(dat),
        .overflow_flag_clr(st[9]), .match_flag_clr_a(st[10]),
        .match_flag_clr_b(st[11]), .match_flag_clr_c(st[12]),
        .capture_flag_clr(st[13]), .port_value_a(pv[0]),
        .port_value_b(pv[1]), .port_value_c(pv[2]),
        .output_pin_direction_bit_a(dr[0]),
        .output_pin_direction_bit_b(dr[1]),
        .output_pin_direction_bit_c(dr[2]),
        .counter_value(cnt), .capture_top_reg(cap),
        .channel_a_compare_reg(cmp_a), .channel_b_compare_reg(cmp_b),
        .channel_c_compare_reg(cmp_c), .overflow_flag(ovf),
        .channel_a_match_flag(mf_a), .channel_b_match_flag(mf_b),
        .channel_c_match_flag(xo[5]), .capture_event_flag(cap_f),
        .channel_a_output_state(s_a), .channel_b_output_state(s_b),
        .channel_c_output_state(xo[4]), .pin_out_a(po_a), .pin_out_b(xo[3]),
        .pin_out_c(xo[2]), .pin_oe_n_a(oen_a), .pin_oe_n_b(xo[1]),
        .pin_oe_n_c(xo[0])
    );

    always #4 clk = ~clk;

    // =================================================================
    // Access tasks
    task chk(input [15:0] g, input [15:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error t=%0t got %h expected %h", $time, g, e);
        end
    end
    endtask

    // One strobe pulse; data bus shared by all write strobes
    task pl(input integer k, input [15:0] d);
    begin
        @(posedge clk) st[k] <= 1'b1;
        dat <= d;
        @(posedge clk) st[k] <= 1'b0;
        #1;
    end
    endtask

    task tk(input integer n);
    begin
        @(posedge clk) tick <= 1'b1;
        repeat (n) @(posedge clk);
        tick <= 1'b0;
        #1;
    end
    endtask

    // Waits one more edge so the registered pin outputs settle
    task cfg(input [3:0] w, input [5:0] m, input [2:0] p, input [2:0] d);
    begin
        @(posedge clk) wgm <= w;
        om <= m;
        pv <= p;
        dr <= d;
        @(posedge clk);
        #1;
    end
    endtask

    task tally_and_finish;
    begin
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end

    // =================================================================
    // Main sequence
    initial
    begin
        n_mismatch = 0;
        total_checks = 0;
        clk = 1'b0;
        srst = 1'b1;
        tick = 1'b0;
        wgm = 4'h0;
        om = 6'h3f;
        st = 14'h0000;
        dat = 16'h0000;
        pv = 3'h7;
        dr = 3'h7;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(s_a, 0);
        chk(oen_a, 1);
        chk(cnt, 0);
        chk(xo, 6'h03);
        chk(cmp_c, 0);
        cfg(4'h0, 6'h00, 3'h0, 3'h0);
        pl(8, 16'hfffe);
        tk(1);
        chk(cnt, 16'hffff);
        chk(ovf, 0);
        tk(1);
        chk(cnt, 16'h0000);
        chk(ovf, 1);
        pl(9, 0);
        chk(ovf, 0);
        for (i = 0; i < 4; i = i + 1)
        begin
            cfg(4'h0, {4'h0, fc_tab[2*i +: 2]}, 3'h0, 3'h0);
            pl(0, 0);
            chk(s_a, fx_tab[i]);
        end
        chk(oen_a, 1);
        cfg(4'h0, 6'h01, 3'h0, 3'h1);
        chk(oen_a, 0);
        chk(po_a, 1);
        cfg(4'h0, 6'h00, 3'h0, 3'h1);
        chk(po_a, 0);
        cfg(4'h0, 6'h3f, 3'h7, 3'h6);
        chk(xo, 6'h00);
        pl(13, 0);
        pl(7, 0);
        chk(cap_f, 1);
        // Clear on compare A with toggle, then a missed top
        cfg(4'h4, 6'h01, 3'h0, 3'h1);
        pl(3, 16'h0002);
        chk(cmp_a, 16'h0002);
        pl(8, 0);
        pl(10, 0);
        s0 = s_a;
        tk(3);
        chk(cnt, 0);
        chk(mf_a, 1);
        chk(s_a, !s0);
        pl(9, 0);
        pl(8, 16'hfffe);
        tk(2);
        chk(cnt, 0);
        chk(ovf, 1);
        cfg(4'hc, 6'h00, 3'h0, 3'h0);
        pl(6, 16'h0003);
        chk(cap, 16'h0003);
        pl(8, 0);
        pl(13, 0);
        tk(4);
        chk(cnt, 0);
        chk(cap_f, 1);
        // Fast PWM, 8-bit: buffered, masked compares
        cfg(4'h5, 6'h0e, 3'h0, 3'h1);
        pl(3, 16'h1234);
        pl(4, 16'h1234);
        chk(cmp_a, 16'h0002);
        pl(9, 0);
        pl(8, 16'h00fd);
        tk(3);
        chk(cnt, 0);
        chk(ovf, 1);
        chk(cmp_a, 16'h0034);
        chk(s_a, 1);
        chk(s_b, 0);
        pl(10, 0);
        tk(16'h35);
        chk(s_a, 0);
        chk(s_b, 1);
        chk(mf_a, 1);
        chk(cmp_b, 16'h0034);
        for (i = 0; i < 5; i = i + 1)
        begin
            cfg(md_tab[4*i +: 4], 6'h0e, 3'h0, 3'h0);
            pl(9, 0);
            pl(8, tp_tab[16*i +: 16] - 16'h0001);
            tk(2);
            chk(cnt, 0);
            chk(ovf, 1);
        end
        // Smallest capture top, compare B above it
        cfg(4'he, 6'h0e, 3'h0, 3'h0);
        pl(8, 0);
        pl(11, 0);
        pl(13, 0);
        tk(8);
        chk(cnt, 0);
        chk(cap_f, 1);
        chk(mf_b, 0);
        tally_and_finish;
    end
endmodule // tb

`default_nettype wire
